/* File: common/fcp_pkg.sv */
// Purpose : Shared constants for the cascadable parity FIFO block
// Assumes : 18-bit words, AHB-Lite register access with 32-bit data
// Notes   : Register offsets are byte addresses of aligned words

package fcp_pkg;

	// ----------------------------------------------------------------
	// Data path
	// ----------------------------------------------------------------
	localparam int unsigned WORD_W    = 18;
	localparam int unsigned DEPTH_DEF = 64;
	localparam int unsigned THR_W     = 16;
	localparam int unsigned LO_PAR    = 8;   // Ninth bit of the low half
	localparam int unsigned HI_PAR    = 17;  // Ninth bit of the high half

	// Program word parity fields
	localparam int unsigned PAR_EN_BIT  = 17;
	localparam int unsigned PAR_CHK_BIT = 16;
	localparam int unsigned PAR_ODD_BIT = 15;
	localparam logic [WORD_W-1:0] PROG_RST = 18'h00000;

	// Threshold defaults, distance from the boundary in words
	localparam logic [THR_W-1:0] AE_THR_RST = 16'h0010;
	localparam logic [THR_W-1:0] AF_THR_RST = 16'h0010;
	localparam logic             AE_RST     = 1'b1;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int unsigned DEC_W = 8;
	localparam logic [DEC_W-1:0] ADDR_CTRL   = 8'h00;
	localparam logic [DEC_W-1:0] ADDR_PROG   = 8'h04;
	localparam logic [DEC_W-1:0] ADDR_AE_THR = 8'h08;
	localparam logic [DEC_W-1:0] ADDR_AF_THR = 8'h0c;
	localparam logic [DEC_W-1:0] ADDR_STATUS = 8'h10;

	localparam int unsigned CTRL_CASCADE = 0;

	// Status field positions
	localparam int unsigned ST_EMPTY  = 0;
	localparam int unsigned ST_FULL   = 1;
	localparam int unsigned ST_AE     = 2;
	localparam int unsigned ST_HF     = 3;
	localparam int unsigned ST_AF     = 4;
	localparam int unsigned ST_WTOK   = 5;
	localparam int unsigned ST_RTOK   = 6;
	localparam int unsigned ST_FIRST  = 7;
	localparam int unsigned ST_COUNT  = 16;

	localparam logic [1:0] HRESP_OKAY = 2'b00;

	// ----------------------------------------------------------------
	// Start-up sequencing
	// ----------------------------------------------------------------
	localparam logic [1:0] STRAP_WAIT = 2'h3;

	typedef enum logic [1:0] {
		FCP_ST_RESET = 2'b00,
		FCP_ST_STRAP = 2'b01,
		FCP_ST_RUN   = 2'b10
	} fcp_state_e;

endpackage : fcp_pkg

/* File: hdl/fcp_sync.sv */
// Purpose : Two-stage synchroniser for a bundle of pin levels
// Assumes : Each bit is an independent level from outside the clock domain
// Notes   : Only the second stage leaves this module
`timescale 1ns/1ps

module fcp_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);

	logic [W-1:0] meta_q;

	// Two flip-flops in series
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= '0;
			o_q    <= '0;
		end else begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end

endmodule : fcp_sync

/* File: hdl/fcp_fifo.sv */
// Purpose : Cascadable 18-bit FIFO with parity and almost-empty update
// Assumes : Write and read clock pins are sampled on I_SYS_CLK
// Notes   : Registers over AHB-Lite, zero wait states
//
// Overview of operation
// - First device gets both tokens after reset
// - Only one device holds read enable
// - Token holder pulses expansion output to hand over
// - Output floats on next read edge
// - Program write configures every device identically
// - Cascaded: parity only, almost flags unavailable
// - Program read: first device drives program word
// - Program read: other devices keep outputs floating
// - Program bits select parity enable, check, odd
// - Check mode reports mismatch when word read
// - Read at 34 words clears almost-empty
// - Read from 33 to 32 sets almost-empty
// - Almost-empty on read edges, others write edges
// - Generate mode stores and outputs computed parity
// - Check mode clears ninth bit on error
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps

module fcp_fifo #(
	parameter int unsigned DEPTH = fcp_pkg::DEPTH_DEF
) (
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_RST,
	// AHB-Lite slave
	input  wire logic        I_HSEL,
	input  wire logic [31:0] I_HADDR,
	input  wire logic [1:0]  I_HTRANS,
	input  wire logic        I_HWRITE,
	input  wire logic [2:0]  I_HSIZE,
	input  wire logic [31:0] I_HWDATA,
	input  wire logic        I_HREADY,
	output logic      [31:0] O_HRDATA,
	output logic             O_HREADYOUT,
	output logic      [1:0]  O_HRESP,
	// FIFO pins
	input  wire logic        I_WRITE_CLOCK,
	input  wire logic        I_READ_CLOCK,
	input  wire logic        I_WRITE_ENABLE_N,
	input  wire logic        I_READ_ENABLE_N,
	input  wire logic [17:0] I_DATA,
	input  wire logic        I_PROG_WRITE,
	input  wire logic        I_PROG_READ,
	input  wire logic        I_FIRST_DEVICE_STRAP_N,
	input  wire logic        I_EXPANSION_IN_WR_N,
	input  wire logic        I_EXPANSION_IN_RD_N,
	output logic             O_EXPANSION_OUT_WR_N,
	output logic             O_EXPANSION_OUT_RD_N,
	output logic      [17:0] O_Q,
	output logic             O_Q_OE,
	output logic      [1:0]  O_PARITY_GEN_OUT,
	output logic      [1:0]  O_PARITY_ERROR_OUT_N,
	output logic             O_EMPTY_N,
	output logic             O_FULL_N,
	output logic             O_ALMOST_EMPTY_STATE,
	output logic             O_HALF_FULL_FLAG,
	output logic             O_PROGRAMMABLE_ALMOST_FLAG
);

	localparam int unsigned PTR_W = $clog2(DEPTH);
	localparam int unsigned CNT_W = PTR_W + 1;
	localparam int unsigned SYN_W = 27;
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);
	localparam logic [CNT_W-1:0] CNT_HALF = CNT_W'(DEPTH / 2);
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Parity bit that makes a byte even or odd overall
	function automatic logic gen_par(input logic [7:0] b, input logic odd);
		gen_par = (^b) ^ odd;
	endfunction : gen_par

	// High when a nine-bit half matches the selected parity
	function automatic logic chk_ok(input logic [8:0] h, input logic odd);
		chk_ok = ((^h) == odd);
	endfunction : chk_ok

	// Circular pointer advance
	function automatic logic [PTR_W-1:0] ptr_inc(input logic [PTR_W-1:0] p);
		if (p == PTR_W'(DEPTH - 1)) begin
			ptr_inc = '0;
		end else begin
			ptr_inc = p + PTR_W'(1);
		end
	endfunction : ptr_inc

	// ----------------------------------------------------------------
	// Pin synchronisation
	// ----------------------------------------------------------------
	logic [SYN_W-1:0] syn;
	logic             s_wclk;
	logic             s_rclk;
	logic             s_wen_n;
	logic             s_ren_n;
	logic [17:0]      s_data;
	logic             s_prog_w;
	logic             s_prog_r;
	logic             s_strap_n;
	logic             s_xi_wr_n;
	logic             s_xi_rd_n;

	fcp_sync #(
		.W (SYN_W)
	) u_sync (
		.i_clk (I_SYS_CLK),
		.i_rst (I_RST),
		.i_d   ({I_WRITE_CLOCK, I_READ_CLOCK, I_WRITE_ENABLE_N, I_READ_ENABLE_N,
		         I_DATA, I_PROG_WRITE, I_PROG_READ, I_FIRST_DEVICE_STRAP_N,
		         I_EXPANSION_IN_WR_N, I_EXPANSION_IN_RD_N}),
		.o_q   (syn)
	);

	// Split the synchronised bundle
	assign {s_wclk, s_rclk, s_wen_n, s_ren_n, s_data, s_prog_w, s_prog_r,
	        s_strap_n, s_xi_wr_n, s_xi_rd_n} = syn;

	// ----------------------------------------------------------------
	// Edge detection on synchronised pins
	// ----------------------------------------------------------------
	logic wclk_q;
	logic rclk_q;
	logic xi_wr_q;
	logic xi_rd_q;
	logic wr_tick;
	logic rd_tick;
	logic xi_wr_hit;
	logic xi_rd_hit;

	// Previous samples for edge detection
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			wclk_q  <= 1'b0;
			rclk_q  <= 1'b0;
			xi_wr_q <= 1'b0;
			xi_rd_q <= 1'b0;
		end else begin
			wclk_q  <= s_wclk;
			rclk_q  <= s_rclk;
			xi_wr_q <= s_xi_wr_n;
			xi_rd_q <= s_xi_rd_n;
		end
	end

	// Rising clock edges and falling expansion edges
	assign wr_tick   = s_wclk & ~wclk_q;
	assign rd_tick   = s_rclk & ~rclk_q;
	assign xi_wr_hit = ~s_xi_wr_n & xi_wr_q;
	assign xi_rd_hit = ~s_xi_rd_n & xi_rd_q;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [31:0]       ctrl_q;
	logic [17:0]       prog_q;
	logic [15:0]       ae_thr_q;
	logic [15:0]       af_thr_q;
	logic              cascade;
	logic              par_en;
	logic              par_chk;
	logic              par_odd;

	assign cascade = ctrl_q[fcp_pkg::CTRL_CASCADE];
	assign par_en  = prog_q[fcp_pkg::PAR_EN_BIT];
	assign par_chk = prog_q[fcp_pkg::PAR_CHK_BIT];
	assign par_odd = prog_q[fcp_pkg::PAR_ODD_BIT];

	// ----------------------------------------------------------------
	// Start-up strap capture
	// ----------------------------------------------------------------
	fcp_pkg::fcp_state_e state_q;
	logic [1:0]          wait_q;
	logic                first_q;

	// Latches the strap once synchronised
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			state_q <= fcp_pkg::FCP_ST_RESET;
			wait_q  <= 2'h0;
			first_q <= 1'b0;
		end else begin
			case (state_q)
				fcp_pkg::FCP_ST_RESET: begin
					state_q <= fcp_pkg::FCP_ST_STRAP;
				end
				fcp_pkg::FCP_ST_STRAP: begin
					wait_q <= wait_q + 2'h1;
					if (wait_q == fcp_pkg::STRAP_WAIT) begin
						first_q <= ~s_strap_n;
						state_q <= fcp_pkg::FCP_ST_RUN;
					end
				end
				fcp_pkg::FCP_ST_RUN: begin
					state_q <= fcp_pkg::FCP_ST_RUN;
				end
				default: begin
					state_q <= fcp_pkg::FCP_ST_RESET;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Tokens and transfer qualification
	// ----------------------------------------------------------------
	logic             run;
	logic             wtok_q;
	logic             rtok_q;
	logic             has_wtok;
	logic             has_rtok;
	logic [CNT_W-1:0] count_q;
	logic [CNT_W-1:0] count_d;
	logic             empty;
	logic             full;
	logic             wr_ok;
	logic             rd_ok;
	logic             wpass;
	logic             rpass;

	assign run      = (state_q == fcp_pkg::FCP_ST_RUN);
	assign has_wtok = ~cascade | wtok_q;
	assign has_rtok = ~cascade | rtok_q;
	assign empty    = (count_q == '0);
	assign full     = (count_q == CNT_FULL);
	assign wr_ok    = run & wr_tick & ~s_wen_n & ~s_prog_w & has_wtok & ~full;
	assign rd_ok    = run & rd_tick & ~s_ren_n & ~s_prog_r & has_rtok & ~empty;

	// Hand over when this device fills or drains
	assign wpass = cascade & wr_ok & ~rd_ok & (count_q == CNT_FULL - CNT_ONE);
	assign rpass = cascade & rd_ok & ~wr_ok & (count_q == CNT_ONE);

	// Token ownership; ring arrival wins
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			wtok_q <= 1'b0;
			rtok_q <= 1'b0;
		end else if (state_q == fcp_pkg::FCP_ST_STRAP && wait_q == fcp_pkg::STRAP_WAIT) begin
			wtok_q <= ~s_strap_n;
			rtok_q <= ~s_strap_n;
		end else begin
			if (xi_wr_hit) begin
				wtok_q <= 1'b1;
			end else if (wpass) begin
				wtok_q <= 1'b0;
			end
			if (xi_rd_hit) begin
				rtok_q <= 1'b1;
			end else if (rpass) begin
				rtok_q <= 1'b0;
			end
		end
	end

	// One-cycle active-low expansion pulses
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_EXPANSION_OUT_WR_N <= 1'b1;
			O_EXPANSION_OUT_RD_N <= 1'b1;
		end else begin
			O_EXPANSION_OUT_WR_N <= ~wpass;
			O_EXPANSION_OUT_RD_N <= ~rpass;
		end
	end

	// ----------------------------------------------------------------
	// Storage and pointers
	// ----------------------------------------------------------------
	logic [17:0]      mem [DEPTH];
	logic [PTR_W-1:0] wptr_q;
	logic [PTR_W-1:0] rptr_q;
	logic [17:0]      wword;
	logic [17:0]      rword;

	// Word as stored, with parity bits replaced per mode
	always_comb begin
		wword = s_data;
		if (par_en && !par_chk) begin
			wword[fcp_pkg::LO_PAR] = gen_par(s_data[7:0], par_odd);
			wword[fcp_pkg::HI_PAR] = gen_par(s_data[16:9], par_odd);
		end else if (par_en && par_chk) begin
			wword[fcp_pkg::LO_PAR] = chk_ok(s_data[8:0], par_odd);
			wword[fcp_pkg::HI_PAR] = chk_ok(s_data[17:9], par_odd);
		end
	end

	assign rword = mem[rptr_q];

	// Memory write
	always_ff @(posedge I_SYS_CLK) begin
		if (wr_ok) begin
			mem[wptr_q] <= wword;
		end
	end

	// Pointers and word count
	assign count_d = count_q + CNT_W'(wr_ok) - CNT_W'(rd_ok);

	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			wptr_q  <= '0;
			rptr_q  <= '0;
			count_q <= '0;
		end else begin
			if (wr_ok) begin
				wptr_q <= ptr_inc(wptr_q);
			end
			if (rd_ok) begin
				rptr_q <= ptr_inc(rptr_q);
			end
			count_q <= count_d;
		end
	end

	// ----------------------------------------------------------------
	// Flags
	// ----------------------------------------------------------------
	logic ae_q;
	logic hf_q;
	logic af_q;

	// Almost-empty follows read edges only, enable or not
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			ae_q <= fcp_pkg::AE_RST;
		end else if (run && rd_tick) begin
			ae_q <= ~cascade & ({{(16-CNT_W){1'b0}}, count_d} <= ae_thr_q);
		end
	end

	// Half-full and almost-full follow write edges only
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			hf_q <= 1'b0;
			af_q <= 1'b0;
		end else if (run && wr_tick) begin
			hf_q <= (count_d > CNT_HALF);
			af_q <= ~cascade & ({{(16-CNT_W){1'b0}}, count_d} + af_thr_q
			        >= {{(16-CNT_W){1'b0}}, CNT_FULL});
		end
	end

	assign O_EMPTY_N                  = ~empty;
	assign O_FULL_N                   = ~full;
	assign O_ALMOST_EMPTY_STATE       = ae_q;
	assign O_HALF_FULL_FLAG           = hf_q;
	assign O_PROGRAMMABLE_ALMOST_FLAG = ae_q | af_q;

	// ----------------------------------------------------------------
	// Output bus and parity pins
	// ----------------------------------------------------------------

	// Read data, program read, and bus enable
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_Q                  <= '0;
			O_Q_OE               <= 1'b0;
			O_PARITY_GEN_OUT     <= 2'h0;
			O_PARITY_ERROR_OUT_N <= 2'h3;
		end else if (run && s_prog_r) begin
			O_Q_OE <= first_q;
			if (first_q) begin
				O_Q <= prog_q;
			end
		end else begin
			if (rd_tick) begin
				O_Q_OE <= has_rtok;
			end
			if (rd_ok) begin
				O_Q <= rword;
				if (par_en && !par_chk) begin
					O_PARITY_GEN_OUT <= {rword[fcp_pkg::HI_PAR], rword[fcp_pkg::LO_PAR]};
				end else begin
					O_PARITY_GEN_OUT <= 2'h0;
				end
				if (par_en && par_chk) begin
					O_PARITY_ERROR_OUT_N <= {rword[fcp_pkg::HI_PAR], rword[fcp_pkg::LO_PAR]};
				end else begin
					O_PARITY_ERROR_OUT_N <= 2'h3;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// AHB-Lite slave
	// ----------------------------------------------------------------
	logic                    dp_wr_q;
	logic [fcp_pkg::DEC_W-1:0] dp_addr_q;
	logic                    ap_take;
	logic [fcp_pkg::DEC_W-1:0] ap_addr;
	logic [31:0]             status;

	assign ap_take = I_HSEL & I_HREADY & I_HTRANS[1];
	assign ap_addr = I_HADDR[fcp_pkg::DEC_W-1:0];

	// Status word
	always_comb begin
		status = 32'h00000000;
		status[fcp_pkg::ST_EMPTY] = empty;
		status[fcp_pkg::ST_FULL]  = full;
		status[fcp_pkg::ST_AE]    = ae_q;
		status[fcp_pkg::ST_HF]    = hf_q;
		status[fcp_pkg::ST_AF]    = af_q;
		status[fcp_pkg::ST_WTOK]  = wtok_q;
		status[fcp_pkg::ST_RTOK]  = rtok_q;
		status[fcp_pkg::ST_FIRST] = first_q;
		status[fcp_pkg::ST_COUNT +: CNT_W] = count_q;
	end

	// Address phase capture and read data
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			dp_wr_q   <= 1'b0;
			dp_addr_q <= '0;
			O_HRDATA  <= 32'h00000000;
		end else if (I_HREADY) begin
			dp_wr_q   <= ap_take & I_HWRITE;
			dp_addr_q <= ap_addr;
			if (ap_take && !I_HWRITE) begin
				case (ap_addr)
					fcp_pkg::ADDR_CTRL:   O_HRDATA <= ctrl_q;
					fcp_pkg::ADDR_PROG:   O_HRDATA <= {14'h0000, prog_q};
					fcp_pkg::ADDR_AE_THR: O_HRDATA <= {16'h0000, ae_thr_q};
					fcp_pkg::ADDR_AF_THR: O_HRDATA <= {16'h0000, af_thr_q};
					fcp_pkg::ADDR_STATUS: O_HRDATA <= status;
					default:              O_HRDATA <= 32'h00000000;
				endcase
			end
		end
	end

	// Writable registers; pin program write and bus write share prog_q
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			ctrl_q   <= 32'h00000000;
			prog_q   <= fcp_pkg::PROG_RST;
			ae_thr_q <= fcp_pkg::AE_THR_RST;
			af_thr_q <= fcp_pkg::AF_THR_RST;
		end else if (dp_wr_q) begin
			case (dp_addr_q)
				fcp_pkg::ADDR_CTRL: ctrl_q <= {31'h00000000, I_HWDATA[fcp_pkg::CTRL_CASCADE]};
				fcp_pkg::ADDR_PROG: prog_q <= I_HWDATA[17:0];
				fcp_pkg::ADDR_AE_THR: begin
					if (!cascade) begin
						ae_thr_q <= I_HWDATA[15:0];
					end
				end
				fcp_pkg::ADDR_AF_THR: begin
					if (!cascade) begin
						af_thr_q <= I_HWDATA[15:0];
					end
				end
				default: begin
					ctrl_q <= ctrl_q;
				end
			endcase
		end else if (run && wr_tick && s_prog_w) begin
			prog_q <= s_data;
		end
	end

	assign O_HREADYOUT = 1'b1;
	assign O_HRESP     = fcp_pkg::HRESP_OKAY;

endmodule : fcp_fifo

/* File: tb/fcp_fifo_chk_assertions.sv */
// Purpose : Port checks for the parity FIFO
// Assumes : Pin clocks are levels sampled on I_SYS_CLK
// Notes   : Bound from the bench top
`timescale 1ns/1ps

module fcp_fifo_chk (
	input  wire logic        I_SYS_CLK,
	input  wire logic        I_RST,
	input  wire logic        I_READ_CLOCK,
	input  wire logic        I_WRITE_CLOCK,
	input  wire logic        I_PROG_READ,
	input  wire logic        I_FIRST_DEVICE_STRAP_N,
	input  wire logic        O_HREADYOUT,
	input  wire logic [1:0]  O_HRESP,
	input  wire logic        O_EXPANSION_OUT_WR_N,
	input  wire logic        O_EXPANSION_OUT_RD_N,
	input  wire logic [17:0] O_Q,
	input  wire logic        O_Q_OE,
	input  wire logic [1:0]  O_PARITY_GEN_OUT,
	input  wire logic [1:0]  O_PARITY_ERROR_OUT_N,
	input  wire logic        O_EMPTY_N,
	input  wire logic        O_FULL_N,
	input  wire logic        O_ALMOST_EMPTY_STATE,
	input  wire logic        O_HALF_FULL_FLAG
);
	logic       rd_q, wr_q, pr_q;
	logic [3:0] rd_age_q, wr_age_q, pr_age_q;

	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);

	function automatic logic [3:0] sat(input logic [3:0] v);
		return (v == 4'hf) ? v : v + 4'h1;
	endfunction : sat

	// Cycles since each rising clock edge or program read change
	always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			rd_q     <= 1'b0;
			wr_q     <= 1'b0;
			pr_q     <= 1'b0;
			rd_age_q <= 4'hf;
			wr_age_q <= 4'hf;
			pr_age_q <= 4'hf;
		end else begin
			rd_q     <= I_READ_CLOCK;
			wr_q     <= I_WRITE_CLOCK;
			pr_q     <= I_PROG_READ;
			rd_age_q <= (I_READ_CLOCK && !rd_q) ? 4'h0 : sat(rd_age_q);
			wr_age_q <= (I_WRITE_CLOCK && !wr_q) ? 4'h0 : sat(wr_age_q);
			pr_age_q <= (I_PROG_READ != pr_q) ? 4'h0 : sat(pr_age_q);
		end
	end

	a_bus_okay: assert property (O_HREADYOUT && O_HRESP == fcp_pkg::HRESP_OKAY)
		else $error("bus stall or error");
	a_ae_read_side: assert property ($changed(O_ALMOST_EMPTY_STATE) |-> rd_age_q <= 4'h6)
		else $error("almost empty moved off read edge");
	a_hf_write_side: assert property ($changed(O_HALF_FULL_FLAG) |-> wr_age_q <= 4'h6)
		else $error("half full moved off write edge");
	a_xo_rd_pulse: assert property ($fell(O_EXPANSION_OUT_RD_N) |=> O_EXPANSION_OUT_RD_N)
		else $error("read expansion pulse longer than one cycle");
	a_xo_wr_pulse: assert property ($fell(O_EXPANSION_OUT_WR_N) |=> O_EXPANSION_OUT_WR_N)
		else $error("write expansion pulse longer than one cycle");
	a_q_read_edge: assert property (($changed(O_Q) || $changed(O_Q_OE)) |->
		(rd_age_q <= 4'h6 || pr_age_q <= 4'h6))
		else $error("output bus moved without a read edge");
	a_parity_modes: assert property (O_PARITY_GEN_OUT != 2'b00 |-> O_PARITY_ERROR_OUT_N == 2'b11)
		else $error("parity outputs both active");
	a_prog_read_oe: assert property (I_PROG_READ [*5] |-> O_Q_OE == !I_FIRST_DEVICE_STRAP_N)
		else $error("program read drive wrong");
	a_flag_excl: assert property (O_EMPTY_N || O_FULL_N)
		else $error("empty and full flagged together");
endmodule : fcp_fifo_chk

/* File: tb/fcp_ring_peer.sv */
// Purpose : Rest of the cascade ring
// Assumes : Neighbour strapped high
// Notes   : Write token returns promptly, read token slowly
`timescale 1ns/1ps

module fcp_ring_peer #(
	parameter int unsigned WR_DLY = 2,
	parameter int unsigned RD_DLY = 200
) (
	input  wire logic       i_clk,
	input  wire logic       i_xo_wr_n,
	input  wire logic       i_xo_rd_n,
	output logic            o_xi_wr_n = 1'b1,
	output logic            o_xi_rd_n = 1'b1,
	output logic      [7:0] o_wr_tok = 8'h0,
	output logic      [7:0] o_rd_tok = 8'h0
);
	localparam logic STRAP_N = 1'b1; // Not the first device

	// Take the write token, return it
	always begin
		@(negedge i_xo_wr_n);
		o_wr_tok <= o_wr_tok + 8'h1;
		repeat (WR_DLY) @(posedge i_clk);
		o_xi_wr_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		o_xi_wr_n <= 1'b1;
	end

	// Read token, after a long hold
	always begin
		@(negedge i_xo_rd_n);
		o_rd_tok <= o_rd_tok + 8'h1;
		repeat (RD_DLY) @(posedge i_clk);
		o_xi_rd_n <= 1'b0;
		repeat (3) @(posedge i_clk);
		o_xi_rd_n <= 1'b1;
	end
endmodule : fcp_ring_peer

/* File: tb/tb_fifo_cascade_parity_flags.sv */
// Purpose : Bench for the parity FIFO
// Assumes : Ring peer model for the rest
// Notes   : Seeded random data, corner words
`timescale 1ns/1ps

module tb_fifo_cascade_parity_flags;
	logic        clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'b00;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, rdv;
	logic        wclk = 1'b0, rclk = 1'b0, wen_n = 1'b1, ren_n = 1'b1, pwr = 1'b0, prd = 1'b0;
	logic [17:0] din = 18'h0, qv;
	logic [2:0]  mode = 3'b000;
	logic        strap_n = 1'b0;
	logic [2:0]  modes [5] = '{3'b000, 3'b100, 3'b101, 3'b110, 3'b111};
	logic [7:0]  tw, tr;
	logic [19:0] refq [$];
	int          fails = 0, cmp_count = 0, cyc = 0;
	wire logic [31:0] hrdata;
	wire logic [17:0] q;
	wire logic [1:0]  hresp, pg, pe_n;
	wire logic [7:0]  wr_tok, rd_tok;
	wire logic        hready, xo_wr_n, xo_rd_n, xi_wr_n, xi_rd_n, q_oe, empty_n, full_n, ae, hf;

	fcp_fifo #(.DEPTH(64)) DUT (
		.I_SYS_CLK(clk), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
		.I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
		.O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .I_WRITE_CLOCK(wclk),
		.I_READ_CLOCK(rclk), .I_WRITE_ENABLE_N(wen_n), .I_READ_ENABLE_N(ren_n), .I_DATA(din),
		.I_PROG_WRITE(pwr), .I_PROG_READ(prd), .I_FIRST_DEVICE_STRAP_N(strap_n),
		.I_EXPANSION_IN_WR_N(xi_wr_n), .I_EXPANSION_IN_RD_N(xi_rd_n),
		.O_EXPANSION_OUT_WR_N(xo_wr_n), .O_EXPANSION_OUT_RD_N(xo_rd_n), .O_Q(q), .O_Q_OE(q_oe),
		.O_PARITY_GEN_OUT(pg), .O_PARITY_ERROR_OUT_N(pe_n), .O_EMPTY_N(empty_n),
		.O_FULL_N(full_n), .O_ALMOST_EMPTY_STATE(ae), .O_HALF_FULL_FLAG(hf),
		.O_PROGRAMMABLE_ALMOST_FLAG());

	// Shares the system clock with the device
	fcp_ring_peer u_peer (.i_clk(clk), .i_xo_wr_n(xo_wr_n), .i_xo_rd_n(xo_rd_n),
		.o_xi_wr_n(xi_wr_n), .o_xi_rd_n(xi_rd_n), .o_wr_tok(wr_tok), .o_rd_tok(rd_tok));

	// Clock and hang limit
	always #50 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			fails++;
			final_report();
		end
	end

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// Single word transfer: address phase, then data phase
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hsel   <= 1'b0;
		hwdata <= wd;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask : ahb

	// One write or read clock pulse, four cycles high and four low
	task automatic pin(input logic w, input logic en, input logic [17:0] d);
		@(posedge clk);
		din <= d;
		if (w) begin
			wclk  <= 1'b1;
			wen_n <= !en;
		end else begin
			rclk  <= 1'b1;
			ren_n <= !en;
		end
		repeat (4) @(posedge clk);
		wclk <= 1'b0;
		rclk <= 1'b0;
		repeat (4) @(posedge clk);
	endtask : pin

	// Write a word and queue what it should read back as
	task automatic wr(input logic [17:0] d);
		logic [17:0] s;
		logic [1:0]  er;
		s  = d;
		er = {^d[17:9], ^d[8:0]} ^ {2{mode[0]}};
		if (mode[2:1] == 2'b10) begin
			s[8]  = ^d[7:0] ^ mode[0];
			s[17] = ^d[16:9] ^ mode[0];
		end
		if (mode[2:1] == 2'b11) begin
			s[8]  = s[8] & !er[0];
			s[17] = s[17] & !er[1];
		end else begin
			er = 2'b00;
		end
		pin(1'b1, 1'b1, d);
		refq.push_back({er, s});
	endtask : wr

	// Read a word; in check mode a good ninth bit is left unchecked
	task automatic rd_chk();
		logic [19:0] e;
		logic [17:0] m;
		e = refq.pop_front();
		m = 18'h3ffff;
		if (mode[2:1] == 2'b11) begin
			m = 18'h1feff | {e[19], 8'h00, e[18], 8'h00};
		end
		pin(1'b0, 1'b1, 18'h0);
		chk("read word", 32'(e[17:0] & m), 32'(q & m));
		chk("parity out", (mode[2:1] == 2'b10) ? 32'({e[17], e[8]}) : 32'h0, 32'(pg));
		chk("parity error", {30'h0, ~e[19:18]}, 32'(pe_n));
	endtask : rd_chk

	task automatic cnt_chk(input logic [15:0] n, input logic a);
		logic [31:0] s;
		ahb(1'b0, fcp_pkg::ADDR_STATUS, 32'h0, s);
		chk("word count", 32'(n), 32'(s[31:16]));
		chk("almost empty", 32'(a), 32'(ae));
	endtask : cnt_chk

	task automatic do_reset();
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (12) @(posedge clk);
	endtask : do_reset

	// Main sequence
	initial begin
		void'($urandom(32'hbf0ed94c));
		do_reset();
		ahb(1'b0, fcp_pkg::ADDR_STATUS, 32'h0, rdv);
		chk("status", 32'h7, 32'({rdv[fcp_pkg::ST_FIRST], rdv[2], rdv[0]}));
		ahb(1'b0, 8'h20, 32'h0, rdv);
		chk("unmapped read", 32'h0, rdv);
		foreach (modes[i]) begin
			mode = modes[i];
			ahb(1'b1, fcp_pkg::ADDR_PROG, {14'h0, mode, 15'h0}, rdv);
			ahb(1'b0, fcp_pkg::ADDR_PROG, 32'h0, rdv);
			chk("program word", {14'h0, mode, 15'h0}, rdv);
			wr(18'h00000);
			wr(18'h3ffff);
			repeat (2) wr(18'($urandom));
			repeat (4) rd_chk();
		end
		mode = 3'b000;
		ahb(1'b1, fcp_pkg::ADDR_PROG, 32'h0, rdv);
		ahb(1'b1, fcp_pkg::ADDR_AE_THR, 32'h20, rdv);
		repeat (34) wr(18'($urandom));
		chk("ae after writes", 32'h1, 32'(ae));
		chk("hf after writes", 32'h1, 32'(hf));
		rd_chk();
		cnt_chk(16'h21, 1'b0);
		qv = q;
		pin(1'b0, 1'b0, 18'h0);
		cnt_chk(16'h21, 1'b0);
		chk("q after idle read", 32'(qv), 32'(q));
		rd_chk();
		cnt_chk(16'h20, 1'b1);
		repeat (32) rd_chk();
		chk("hf after reads", 32'h1, 32'(hf));
		do_reset();
		ahb(1'b1, fcp_pkg::ADDR_CTRL, 32'h1, rdv);
		ahb(1'b1, fcp_pkg::ADDR_AE_THR, 32'h5, rdv);
		ahb(1'b0, fcp_pkg::ADDR_AE_THR, 32'h0, rdv);
		chk("cascade threshold", 32'(fcp_pkg::AE_THR_RST), rdv);
		mode = 3'b101;
		pwr <= 1'b1;
		pin(1'b1, 1'b0, {mode, 15'h0});
		pwr <= 1'b0;
		ahb(1'b0, fcp_pkg::ADDR_PROG, 32'h0, rdv);
		chk("pin program word", 32'h28000, rdv);
		ahb(1'b0, fcp_pkg::ADDR_STATUS, 32'h0, rdv);
		chk("tokens", 32'h3, 32'({rdv[fcp_pkg::ST_RTOK], rdv[fcp_pkg::ST_WTOK]}));
		prd <= 1'b1;
		repeat (6) @(posedge clk);
		chk("program read data", 32'h28000, 32'(q));
		chk("program read drive", 32'h1, 32'(q_oe));
		prd <= 1'b0;
		repeat (6) @(posedge clk);
		tw = wr_tok;
		tr = rd_tok;
		repeat (64) wr(18'($urandom));
		chk("write token", 32'(tw + 8'h1), 32'(wr_tok));
		rd_chk();
		chk("reader drives bus", 32'h1, 32'(q_oe));
		repeat (63) rd_chk();
		chk("read token", 32'(tr + 8'h1), 32'(rd_tok));
		pin(1'b0, 1'b0, 18'h0);
		chk("bus released", 32'h0, 32'(q_oe));
		repeat (250) @(posedge clk);
		pin(1'b0, 1'b0, 18'h0);
		chk("token back", 32'h1, 32'(q_oe));
		strap_n <= 1'b1;
		do_reset();
		prd <= 1'b1;
		repeat (6) @(posedge clk);
		chk("other device drive", 32'h0, 32'(q_oe));
		final_report();
	end
endmodule : tb_fifo_cascade_parity_flags

bind fcp_fifo fcp_fifo_chk u_chk (.*);
